// File: pad_router.sv
// Address decoder and SRAM bank router for two cores and two DMA ports.
// Functional notes
// R1: Forty-one peripheral units each get their region; the decode reaches only 40, select line 40 is never set.
// R2: Peripheral decode identical for both cores.
// R3: Process-ID window reaches only own core's unit.
// R4: SDIO slave selected by three separate windows.
// R5: Decode spans peripheral range; MAC 8K, MMU 16K.
// R6: ROM and SRAM answer in one cycle.
// R7: RTC memories and DMA may take extra cycles.
// R8: SRAM split in 32K banks, arbitrated per bank.
// R9: Different banks served concurrently at full rate.
// R10: Bank conflict grants one, stalls the rest.
// R11: Reserved holes select nothing, read zero.
`default_nettype none
module pad_router (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  req_i,
  input  wire logic [3:0]  we_i,
  input  wire logic [127:0] addr_i,
  input  wire logic [127:0] wdata_i,
  input  wire logic [127:0] periph_rdata_i,
  input  wire logic [127:0] sram_rdata_i,
  input  wire logic [127:0] rtc_rdata_i,
  output logic      [3:0]  ready_o,
  output logic      [127:0] rdata_o,
  output logic      [163:0] periph_sel_o,
  output logic      [3:0]  sram_en_o,
  output logic      [15:0] sram_bank_o,
  output logic      [3:0]  rtc_en_o,
  output logic      [3:0]  wr_en_o,
  output logic      [127:0] wdata_o,
  output logic      [127:0] addr_o
);
  localparam int unsigned N = pad_pkg::PAD_REQ_N;

  logic [40:0]            psel     [N];
  logic [N-1:0]           phit;
  pad_pkg::pad_tgt_t      tgt      [N];
  logic [3:0]             bank     [N];
  logic [N-1:0]           grant;
  logic [N-1:0]           busy_reg;
  logic [1:0]             wait_reg [N];
  logic [1:0]             prio_reg;
  logic [N-1:0]           go;

  // Peripheral decoders; each knows which core it serves.
  for (genvar g = 0; g < N; g++) begin : g_dec
    pad_periph_dec #(
      .IS_APPL (g == pad_pkg::PAD_REQ_APPL)
    ) u_dec (
      .addr_i (addr_i[32*g +: 32]),
      .sel_o  (psel[g]),
      .hit_o  (phit[g])
    );
  end

  // Target class and SRAM bank of each request.
  always_comb begin
    logic [31:0] a;
    a = 32'h0;
    for (int r = 0; r < N; r++) begin
      a = addr_i[32*r +: 32];
      bank[r] = 4'(a >> pad_pkg::PAD_BANK_SHIFT); // R8
      if (a >= pad_pkg::PAD_SRAM_LO && a <= pad_pkg::PAD_SRAM_HI) begin
        tgt[r] = pad_pkg::PAD_TGT_SRAM;
      end else if ((a >= pad_pkg::PAD_RTCF_LO && a <= pad_pkg::PAD_RTCF_HI) ||
                   (a >= pad_pkg::PAD_RTCS_LO && a <= pad_pkg::PAD_RTCS_HI)) begin
        tgt[r] = (a >= pad_pkg::PAD_RTCS_LO) ? pad_pkg::PAD_TGT_RTCS : pad_pkg::PAD_TGT_RTCF;
      end else if (phit[r]) begin
        tgt[r] = pad_pkg::PAD_TGT_PERIPH;
      end else begin
        tgt[r] = pad_pkg::PAD_TGT_NONE; // R11
      end
    end
  end

  // Per-bank rotating-priority arbiter; a loser simply retries next cycle.
  always_comb begin
    logic [N-1:0] taken;
    int unsigned  r;
    r     = 0;
    taken = '0;
    grant = '0;
    for (int k = 0; k < N; k++) begin
      r = (int'(prio_reg) + k) % N;
      if (req_i[r] && !busy_reg[r] && tgt[r] == pad_pkg::PAD_TGT_SRAM) begin
        grant[r] = 1'b1; // R9
        for (int q = 0; q < N; q++) begin
          if (taken[q] && bank[q] == bank[r]) begin
            grant[r] = 1'b0; // R10
          end
        end
        taken[r] = grant[r];
      end
    end
  end

  // Which requests complete this cycle.
  always_comb begin
    for (int r = 0; r < N; r++) begin
      case (tgt[r])
        pad_pkg::PAD_TGT_SRAM:   go[r] = grant[r]; // R6
        pad_pkg::PAD_TGT_RTCF,
        pad_pkg::PAD_TGT_RTCS:   go[r] = busy_reg[r] && wait_reg[r] == 2'h0; // R7
        default:                 go[r] = req_i[r] && !busy_reg[r];
      endcase
    end
  end

  // Slow-memory wait counters; the requester holds its request until ready.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        busy_reg[r] <= 1'b0;
        wait_reg[r] <= 2'h0;
      end else if (busy_reg[r]) begin
        if (wait_reg[r] == 2'h0) begin
          busy_reg[r] <= 1'b0;
        end else begin
          wait_reg[r] <= wait_reg[r] - 2'h1;
        end
      end else if (req_i[r] && (tgt[r] == pad_pkg::PAD_TGT_RTCF || tgt[r] == pad_pkg::PAD_TGT_RTCS)) begin
        busy_reg[r] <= 1'b1; // R7
        wait_reg[r] <= 2'(pad_pkg::PAD_SLOW_CYC - 1);
      end
    end
  end

  // Rotate bank priority so no requester starves.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prio_reg <= 2'h0;
    end else if (|grant) begin
      prio_reg <= prio_reg + 2'h1;
    end
  end

  // Peripheral selects pulse only in the cycle that completes the access.
  // A request held high by its master strobes its unit again in every cycle that it stays high.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        periph_sel_o[41*r +: 41] <= '0;
      end else begin
        periph_sel_o[41*r +: 41] <= (go[r] && tgt[r] == pad_pkg::PAD_TGT_PERIPH) ? psel[r] : '0; // R1 R3
      end
    end
  end

  // SRAM grant and bank towards the bank array.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        sram_en_o[r]          <= 1'b0;
        sram_bank_o[4*r +: 4] <= 4'h0;
      end else begin
        sram_en_o[r]          <= grant[r]; // R8
        sram_bank_o[4*r +: 4] <= bank[r];
      end
    end
  end

  // RTC memory strobe, raised only once the slow wait has run out.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        rtc_en_o[r] <= 1'b0;
      end else begin
        rtc_en_o[r] <= go[r] && (tgt[r] == pad_pkg::PAD_TGT_RTCF || tgt[r] == pad_pkg::PAD_TGT_RTCS); // R7
      end
    end
  end

  // Write strobe; a write into a hole is dropped here and nowhere else.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        wr_en_o[r] <= 1'b0;
      end else begin
        wr_en_o[r] <= go[r] && we_i[r] && tgt[r] != pad_pkg::PAD_TGT_NONE; // R11
      end
    end
  end

  // Write data and address copies follow the bus every cycle.
  // The strobes above say when they mean anything; gating them would only cost muxes.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        wdata_o[32*r +: 32] <= 32'h0;
        addr_o[32*r +: 32]  <= 32'h0;
      end else begin
        wdata_o[32*r +: 32] <= wdata_i[32*r +: 32];
        addr_o[32*r +: 32]  <= addr_i[32*r +: 32];
      end
    end
  end

  // Completion pulse, one for each finished access.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        ready_o[r] <= 1'b0;
      end else begin
        ready_o[r] <= go[r]; // R6
      end
    end
  end

  // Read data, taken by the target class of the access; holes answer zero.
  always_ff @(posedge clk_sys_i) begin
    for (int r = 0; r < N; r++) begin
      if (!rst_n_i) begin
        rdata_o[32*r +: 32] <= 32'h0;
      end else begin
        case (tgt[r])
          pad_pkg::PAD_TGT_SRAM:   rdata_o[32*r +: 32] <= sram_rdata_i[32*r +: 32];
          pad_pkg::PAD_TGT_PERIPH: rdata_o[32*r +: 32] <= periph_rdata_i[32*r +: 32];
          pad_pkg::PAD_TGT_RTCF,
          pad_pkg::PAD_TGT_RTCS:   rdata_o[32*r +: 32] <= rtc_rdata_i[32*r +: 32];
          default:                 rdata_o[32*r +: 32] <= 32'h0; // R11
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: pad_pkg.sv
// Package of address map constants and types for the peripheral address decoder.
`default_nettype none
package pad_pkg;
  localparam int unsigned PAD_REQ_N      = 4;                // Protocol core, application core, two DMA ports.
  localparam int unsigned PAD_REQ_PROTO  = 0;
  localparam int unsigned PAD_REQ_APPL   = 1;
  localparam int unsigned PAD_SEL_W      = 41;               // One select line per peripheral unit.
  localparam logic [31:0] PAD_PERIPH_LO  = 32'h3ff0_0000;
  localparam logic [31:0] PAD_PERIPH_HI  = 32'h3ff7_ffff;
  localparam logic [31:0] PAD_PID_BASE   = 32'h3ff1_f000;
  localparam logic [31:0] PAD_PID_LAST   = 32'h3ff1_ffff;
  localparam logic [31:0] PAD_SDIO_A     = 32'h3ff4_b000;
  localparam logic [31:0] PAD_SDIO_B     = 32'h3ff5_5000;
  localparam logic [31:0] PAD_SDIO_C     = 32'h3ff5_8000;
  localparam logic [31:0] PAD_SRAM_LO    = 32'h3ffa_e000;
  localparam logic [31:0] PAD_SRAM_HI    = 32'h3fff_ffff;
  localparam logic [31:0] PAD_RTCF_LO    = 32'h3ff8_0000;
  localparam logic [31:0] PAD_RTCF_HI    = 32'h3ff8_1fff;
  localparam logic [31:0] PAD_RTCS_LO    = 32'h5000_0000;
  localparam logic [31:0] PAD_RTCS_HI    = 32'h5000_1fff;
  localparam int unsigned PAD_BANK_SHIFT = 15;               // 32K banks.
  localparam int unsigned PAD_BANK_W     = 4;
  localparam int unsigned PAD_BANK_N     = 16;
  localparam int unsigned PAD_SLOW_CYC   = 2;                // Extra cycles for RTC memory accesses.
  localparam logic [5:0]  PAD_SEL_PID_PROTO = 6'h06;         // Select index of the protocol core's unit.
  localparam logic [5:0]  PAD_SEL_PID_APPL  = 6'h07;         // Select index of the application core's unit.
  localparam logic [5:0]  PAD_SEL_NONE      = 6'h3f;         // Reserved hole marker.
  // Peripheral windows: base page (address bits 18:12), page count, select index.
  localparam int unsigned PAD_WIN_N = 40;
  localparam logic [6:0] PAD_WIN_PAGE [PAD_WIN_N] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h10, 7'h1f, 7'h40, 7'h42, 7'h43,
    7'h44, 7'h48, 7'h49, 7'h4b, 7'h4c, 7'h4f, 7'h50, 7'h53, 7'h54, 7'h55,
    7'h56, 7'h57, 7'h58, 7'h59, 7'h5a, 7'h5b, 7'h5e, 7'h5f, 7'h60, 7'h64,
    7'h65, 7'h66, 7'h67, 7'h68, 7'h69, 7'h6c, 7'h6d, 7'h6e, 7'h6f, 7'h70};
  localparam logic [2:0] PAD_WIN_CNT [PAD_WIN_N] = '{
    3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
  // The process-ID window (index 6) is replaced per core; the three SDIO parts share index 14.
  localparam logic [5:0] PAD_WIN_SEL [PAD_WIN_N] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a,
    6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h0e,
    6'h14, 6'h15, 6'h0e, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c,
    6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26};
  localparam logic [5:0] PAD_SEL_RNG = 6'h27;                // Random generator at page 7'h75.
  localparam logic [6:0] PAD_RNG_PAGE = 7'h75;
  typedef enum logic [2:0] {
    PAD_TGT_NONE   = 3'h0,
    PAD_TGT_PERIPH = 3'h1,
    PAD_TGT_SRAM   = 3'h2,
    PAD_TGT_RTCF   = 3'h3,
    PAD_TGT_RTCS   = 3'h4
  } pad_tgt_t;
endpackage
`default_nettype wire

// File: pad_periph_dec.sv
// Peripheral window decoder for one requester: address to one-hot unit select.
`default_nettype none
module pad_periph_dec #(
  parameter logic IS_APPL = 1'b0
) (
  input  wire logic [31:0] addr_i,
  output logic      [40:0] sel_o,
  output logic             hit_o
);
  logic [6:0] page;
  logic [5:0] idx;
  logic       in_range;

  // Window search; a reserved hole leaves the index at the none marker.
  always_comb begin
    page     = addr_i[18:12];
    in_range = (addr_i >= pad_pkg::PAD_PERIPH_LO) && (addr_i <= pad_pkg::PAD_PERIPH_HI); // R5
    idx      = pad_pkg::PAD_SEL_NONE;
    for (int w = 0; w < pad_pkg::PAD_WIN_N; w++) begin
      if (page >= pad_pkg::PAD_WIN_PAGE[w] &&
          page < 7'(pad_pkg::PAD_WIN_PAGE[w] + 7'(pad_pkg::PAD_WIN_CNT[w]))) begin
        idx = pad_pkg::PAD_WIN_SEL[w]; // R2 R4 R5
      end
    end
    if (page == pad_pkg::PAD_RNG_PAGE) begin
      idx = pad_pkg::PAD_SEL_RNG;
    end
    // Only the own core's process-ID unit is reachable from this port.
    if (idx == pad_pkg::PAD_SEL_PID_PROTO && IS_APPL) begin
      idx = pad_pkg::PAD_SEL_PID_APPL; // R3
    end
    if (!in_range) begin
      idx = pad_pkg::PAD_SEL_NONE;
    end
    sel_o = '0;
    hit_o = 1'b0;
    if (idx != pad_pkg::PAD_SEL_NONE) begin
      sel_o[idx] = 1'b1; // R1
      hit_o      = 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: pad_tgt_model.sv
// Target model that answers reads from peripherals, SRAM and RTC memory.
`default_nettype none
module pad_tgt_model (
  input  wire logic [127:0] addr_i,
  output logic      [127:0] periph_rdata_o,
  output logic      [127:0] sram_rdata_o,
  output logic      [127:0] rtc_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each target folds its own key into the address, so data from the wrong source shows up.
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      periph_rdata_o[32*r+:32] = addr_i[32*r+:32] ^ 32'h0f0f_0f0f;
      sram_rdata_o[32*r+:32]   = addr_i[32*r+:32] ^ 32'h5a5a_5a5a;
      rtc_rdata_o[32*r+:32]    = addr_i[32*r+:32] ^ 32'hf0f0_f0f0;
    end
  end
endmodule
`default_nettype wire

// File: pad_props.sv
// Checker of the router's port behaviour, bound to the router.
`default_nettype none
module pad_props (
  input wire logic         clk_sys_i,
  input wire logic         rst_n_i,
  input wire logic [3:0]   req_i,
  input wire logic [127:0] addr_i,
  input wire logic [3:0]   ready_o,
  input wire logic [127:0] rdata_o,
  input wire logic [163:0] periph_sel_o,
  input wire logic [3:0]   sram_en_o,
  input wire logic [15:0]  sram_bank_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // RTC memory is slower, so its completion comes after two idle cycles.
  sequence s_rtc_wait;
    !ready_o[0] [*2] ##1 ready_o[0];
  endsequence
  sequence s_rtc_start;
    req_i[0] && !$past(req_i[0]) && addr_i[31:13] == 19'h1ffc0;
  endsequence
  a_rtc_slow_ready: assert property (s_rtc_start |=> s_rtc_wait)
    else $error("RTC access completion not on third cycle");
  a_sram_single_cycle: assert property (sram_en_o[0] |-> ready_o[0])
    else $error("SRAM grant without completion");
  a_sel_one_hot: assert property ($onehot0(periph_sel_o[40:0]))
    else $error("More than one peripheral selected");
  a_pid_own_proto: assert property (ready_o[0] && $past(addr_i[31:12]) == 20'h3ff1f
    |-> periph_sel_o[6] && !periph_sel_o[7])
    else $error("Protocol core reached the wrong process-ID unit");
  a_pid_own_appl: assert property (ready_o[1] && $past(addr_i[63:44]) == 20'h3ff1f
    |-> periph_sel_o[48] && !periph_sel_o[47])
    else $error("Application core reached the wrong process-ID unit");
  a_sdio_three_parts: assert property (ready_o[0] && $past(addr_i[31:12]) inside {20'h3ff4b, 20'h3ff55, 20'h3ff58}
    |-> periph_sel_o[14])
    else $error("SDIO window did not select the SDIO unit");
  a_hole_reads_zero: assert property (ready_o[0] && $past(addr_i[31:12]) == 20'h3ff05
    |-> rdata_o[31:0] == 32'h0 && periph_sel_o[40:0] == 41'h0)
    else $error("Reserved hole selected a unit or returned data");
  a_bank_one_grant: assert property (sram_en_o[0] && sram_en_o[1] |-> sram_bank_o[3:0] != sram_bank_o[7:4])
    else $error("Two grants to one SRAM bank");
endmodule
bind pad_router pad_props u_props (.clk_sys_i, .rst_n_i, .req_i, .addr_i, .ready_o, .rdata_o,
  .periph_sel_o, .sram_en_o, .sram_bank_o);
`default_nettype wire

// File: testbench.sv
// Self-checking testbench of the peripheral address decoder.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, rst_n_i;
  logic [3:0] req, ready_o, we, wr_en_o, rtc_en_o;
  logic [127:0] addr, rdata_o, prd, srd, rrd, wd, wdata_o, addr_o;
  logic [163:0] periph_sel_o;
  logic [31:0] ta [4], got_rd [4], got_wd [4], got_ad [4];
  logic got_wr [4], got_rtc [4];
  logic [40:0] got_sel [4];
  int lat [4];
  int n_errors = 0, checks = 0, cyc = 0;
  pad_tgt_model u_tgt (.addr_i(addr), .periph_rdata_o(prd), .sram_rdata_o(srd), .rtc_rdata_o(rrd));
  pad_router u_dut (.clk_sys_i, .rst_n_i, .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wd),
    .periph_rdata_i(prd), .sram_rdata_i(srd), .rtc_rdata_i(rrd), .ready_o, .rdata_o, .periph_sel_o,
    .sram_en_o(), .sram_bank_o(), .rtc_en_o, .wr_en_o, .wdata_o, .addr_o);
  // Free-running clock of 40 ns.
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Issues the masked ports at once and drops each request on its own ready pulse.
  task automatic run(input logic [3:0] m);
    logic [3:0] pend;
    int n;
    pend = m;
    n = 0;
    for (int r = 0; r < 4; r++) addr[32*r+:32] = ta[r];
    req = m;
    while (pend != 4'h0 && n < 20) begin
      @(negedge clk_sys_i);
      n++;
      for (int r = 0; r < 4; r++) begin
        if (pend[r] && ready_o[r]) begin
          got_rd[r] = rdata_o[32*r+:32];
          got_sel[r] = periph_sel_o[41*r+:41];
          got_wr[r] = wr_en_o[r];
          got_rtc[r] = rtc_en_o[r];
          got_wd[r] = wdata_o[32*r+:32];
          got_ad[r] = addr_o[32*r+:32];
          lat[r] = n;
          pend[r] = 1'b0;
          req[r] = 1'b0;
        end
      end
    end
    chk({60'h0, pend}, 64'h0, "request never completed");
    @(negedge clk_sys_i);
  endtask
  // Both cores see the same unit at the same address, SDIO parts and wide windows included; the process-ID window gives each core its own.
  task automatic t_periph();
    logic [31:0] a [8] = '{32'h3ff0_0000, 32'h3ff1_3000, 32'h3ff4_b000, 32'h3ff5_5000,
                           32'h3ff5_8000, 32'h3ff6_a000, 32'h3ff7_0000, 32'h3ff7_5000};
    int ix [8] = '{0, 5, 14, 14, 14, 33, 38, 39};
    for (int i = 0; i < 8; i++) begin
      ta = '{a[i], a[i], 32'h0, 32'h0};
      run(4'h3);
      for (int r = 0; r < 2; r++) begin
        chk({23'h0, got_sel[r]}, 64'h1 << ix[i], "unit select");
        chk({32'h0, got_rd[r]}, {32'h0, a[i] ^ 32'h0f0f_0f0f}, "unit data");
      end
    end
    ta = '{32'h3ff1_f800, 32'h3ff1_f800, 32'h0, 32'h0};
    run(4'h3);
    chk({23'h0, got_sel[0]}, 64'h1 << 6, "protocol core id unit");
    chk({23'h0, got_sel[1]}, 64'h1 << 7, "application core id unit");
    $display("test periph done");
  endtask
  // Reserved holes select nothing and read zero.
  task automatic t_hole();
    logic [31:0] a [3] = '{32'h3ff0_5000, 32'h3ff4_1000, 32'h3ff7_6000};
    for (int i = 0; i < 3; i++) begin
      ta = '{a[i], a[i], 32'h0, 32'h0};
      run(4'h3);
      chk({23'h0, got_sel[0] | got_sel[1]}, 64'h0, "hole select");
      chk({32'h0, got_rd[0] | got_rd[1]}, 64'h0, "hole data");
    end
    $display("test hole done");
  endtask
  // Four banks in parallel at full rate, then a same-bank clash.
  task automatic t_sram();
    ta = '{32'h3ffb_0000, 32'h3ffb_8000, 32'h3ffc_0000, 32'h3ffc_8004};
    run(4'hf);
    for (int r = 0; r < 4; r++) begin
      chk(lat[r], 64'h1, "bank latency");
      chk({32'h0, got_rd[r]}, {32'h0, ta[r] ^ 32'h5a5a_5a5a}, "sram data");
      chk({63'h0, got_rtc[r]}, 64'h0, "no rtc strobe on sram");
    end
    ta = '{32'h3ffb_0000, 32'h3ffb_0040, 32'h0, 32'h0};
    run(4'h3);
    chk(lat[0] + lat[1], 64'h3, "clash serialised");
    $display("test sram done");
  endtask
  // RTC memory completes after the slow wait.
  task automatic t_rtc();
    ta = '{32'h3ff8_0010, 32'h0, 32'h0, 32'h0};
    run(4'h1);
    chk(lat[0], 64'h3, "rtc latency");
    chk({32'h0, got_rd[0]}, {32'h0, ta[0] ^ 32'hf0f0_f0f0}, "rtc data");
    chk({63'h0, got_rtc[0]}, 64'h1, "rtc strobe");
    $display("test rtc done");
  endtask
  // Writes reach a unit with data and address; a write into a hole is dropped.
  task automatic t_write();
    ta = '{32'h3ff4_0004, 32'h3ff2_0000, 32'h0, 32'h0};
    we = 4'h3;
    wd = {64'h0, 32'h1234_5678, 32'hcafe_0001};
    run(4'h3);
    chk({63'h0, got_wr[0]}, 64'h1, "write strobe");
    chk({63'h0, got_wr[1]}, 64'h0, "hole write strobe");
    chk({32'h0, got_wd[0]}, 64'hcafe_0001, "write data");
    chk({32'h0, got_ad[0]}, {32'h0, ta[0]}, "write address");
    chk({23'h0, got_sel[0]}, 64'h1 << 8, "write unit");
    chk({23'h0, got_sel[1]}, 64'h0, "hole write select");
    we = 4'h0;
    $display("test write done");
  endtask
  // A reset in mid-access clears the slow wait and leaves ready, the port-0 selects and the port-0/1 read data low.
  task automatic t_reset();
    ta = '{32'h3ff8_0020, 32'h0, 32'h0, 32'h0};
    addr[31:0] = ta[0];
    req = 4'h1;
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    req = 4'h0;
    repeat (2) @(negedge clk_sys_i);
    chk({60'h0, ready_o}, 64'h0, "ready in reset");
    chk({23'h0, periph_sel_o[40:0]}, 64'h0, "select in reset");
    chk(rdata_o[63:0], 64'h0, "data in reset");
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    run(4'h1);
    chk(lat[0], 64'h3, "rtc latency after reset");
    $display("test reset done");
  endtask
  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    req = 4'h0;
    addr = 128'h0;
    we = 4'h0;
    wd = 128'h0;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    t_periph();
    t_hole();
    t_sram();
    t_rtc();
    t_write();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
